// *** imu_checker_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module imu_checker
  import imu_regs_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       linkClk,
  input wire logic       linkRead,
  input wire logic       linkWrite,
  input wire logic [7:0] linkRdata,
  input wire logic       linkDone,
  input wire logic       linkBusy,
  input wire logic [1:0] accPmuStatus,
  input wire logic [1:0] gyroPmuStatus,
  input wire logic [1:0] magPmuStatus,
  input wire logic       accLowPowerCmd,
  input wire logic       tempValid,
  input wire logic       tempRunning,
  input wire logic [3:0] accOdr,
  input wire logic       accUndersample,
  input wire logic [2:0] accFilterSel,
  input wire logic [2:0] accAvgDepth,
  input wire logic       accToNormal,
  input wire logic       accLowPowerGo,
  input wire logic       accConfErr
);
  wire logic allSusp;
  wire logic odrBad;
  assign allSusp = {accPmuStatus, gyroPmuStatus, magPmuStatus} == 6'h00;
  assign odrBad = accOdr == 4'h0 || accOdr > ODR_MAX;
  // ==========================================================
  // core domain
  temp_stop_a:
    assert property (@(posedge clk) disable iff (!rstn) allSusp [*2] |-> !tempRunning)
    else $error("temperature runs while suspended");
  temp_valid_a:
    assert property (@(posedge clk) disable iff (!rstn)
      (gyroPmuStatus != PMU_NORMAL) [*2] |-> !tempValid)
    else $error("temperature valid without gyro normal");
  bwp_route_a:
    assert property (@(posedge clk) disable iff (!rstn) $stable(accUndersample)
      |-> (accUndersample ? accFilterSel : accAvgDepth) == 3'h0)
    else $error("bandwidth routed to wrong use");
  odr_error_a:
    assert property (@(posedge clk) disable iff (!rstn) odrBad [*2] |-> accConfErr)
    else $error("reserved rate without error");
  lp_pass_a:
    assert property (@(posedge clk) disable iff (!rstn)
      accLowPowerCmd && accUndersample ##1 accUndersample |-> accLowPowerGo)
    else $error("low power command lost");
  lp_block_a:
    assert property (@(posedge clk) disable iff (!rstn)
      accLowPowerCmd && !accUndersample |=> !accLowPowerGo)
    else $error("low power command passed without undersampling");
  to_normal_a:
    assert property (@(posedge clk) disable iff (!rstn)
      $fell(accUndersample) && accPmuStatus == PMU_LOW_POWER |-> ##[0:2] accToNormal)
    else $error("no move to normal mode");
  // ==========================================================
  // link domain
  link_take_a:
    assert property (@(posedge linkClk) disable iff (!rstn)
      (linkRead || linkWrite) && !linkBusy && !linkDone |=> linkBusy)
    else $error("link request not taken");
  link_answer_a:
    assert property (@(posedge linkClk) disable iff (!rstn)
      $rose(linkBusy) |-> ##[1:16] (linkDone && !linkBusy))
    else $error("link request not answered");
  rdata_hold_a:
    assert property (@(posedge linkClk) disable iff (!rstn) !linkDone |-> $stable(linkRdata))
    else $error("read data moved between answers");
  cover property (@(posedge clk) accLowPowerGo);
  cover property (@(posedge clk) accToNormal);
  cover property (@(posedge linkClk) linkDone && linkRdata == FIFO_EMPTY_BYTE);
endmodule : imu_checker

bind imu_temp_fifo_accel_conf_regs imu_checker imu_checker_inst (
  .clk, .rstn, .linkClk, .linkRead, .linkWrite, .linkRdata, .linkDone, .linkBusy,
  .accPmuStatus, .gyroPmuStatus, .magPmuStatus, .accLowPowerCmd, .tempValid,
  .tempRunning, .accOdr, .accUndersample, .accFilterSel, .accAvgDepth,
  .accToNormal, .accLowPowerGo, .accConfErr
);
`default_nettype wire

// *** imu_link_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module imu_link_host (
  input  wire logic       linkClk,
  input  wire logic       linkDone,
  input  wire logic [7:0] linkRdata,
  output logic            linkStart,
  output logic [7:0]      linkStartAddr,
  output logic            linkRead,
  output logic            linkWrite,
  output logic [7:0]      linkWdata,
  output logic            linkStop
);
  int gap = 0;
  int late = 0;
  initial {linkStart, linkStartAddr, linkRead, linkWrite, linkWdata, linkStop} = '0;
  // ==========================================================
  // one request: 0 read, 1 write, 2 start address, 3 end burst
  // burst reads and writes
  task automatic req(input int k, input logic [7:0] v, output logic [7:0] d);
    int i;
    @(posedge linkClk);
    #2;
    linkRead = k == 0;
    linkWrite = k == 1;
    linkStart = k == 2;
    linkStop = k == 3;
    linkWdata = v;
    linkStartAddr = v;
    @(posedge linkClk);
    #2;
    {linkRead, linkWrite, linkStart, linkStop} = 4'h0;
    linkWdata = ~v;
    linkStartAddr = ~v;
    // an end of burst is answered too; a start sent while busy would be lost
    for (i = 0; k != 2 && i < 40 && linkDone !== 1'h1; i++) @(negedge linkClk);
    if (k != 2 && linkDone !== 1'h1) late++;
    d = linkRdata;
    repeat (gap + 2) @(posedge linkClk);
  endtask : req
endmodule : imu_link_host
`default_nettype wire

// *** imu_regs_pkg.sv ***
package imu_regs_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_TEMP_LSB   = 8'h20;
  localparam logic [7:0] ADDR_TEMP_MSB   = 8'h21;
  localparam logic [7:0] ADDR_FILL_LSB   = 8'h22;
  localparam logic [7:0] ADDR_FILL_MSB   = 8'h23;
  localparam logic [7:0] ADDR_FIFO_PORT  = 8'h24;
  localparam logic [7:0] ADDR_ACCEL_CONF = 8'h40;

  // ==========================================================
  // field layout and reset values
  localparam int          US_BIT          = 7;
  localparam int          BWP_MSB         = 6;
  localparam int          BWP_LSB         = 4;
  localparam int          ODR_MSB         = 3;
  localparam int          ODR_LSB         = 0;
  localparam logic [7:0]  ACCEL_CONF_RST  = 8'h28;
  localparam logic [3:0]  ODR_MIN         = 4'h1;
  localparam logic [3:0]  ODR_MAX         = 4'hC;
  localparam logic [2:0]  BWP_FILTER_MAX  = 3'h2;
  localparam logic [15:0] TEMP_INVALID    = 16'h8000;
  localparam logic [1:0]  PMU_SUSPEND     = 2'h0;
  localparam logic [1:0]  PMU_NORMAL      = 2'h1;
  localparam logic [1:0]  PMU_LOW_POWER   = 2'h2;
  localparam logic [7:0]  FIFO_EMPTY_BYTE = 8'h80;
  localparam logic [7:0]  UNMAPPED_BYTE   = 8'h00;

  // ==========================================================
  // fifo geometry
  localparam int          FIFO_AW    = 10;
  localparam int          FIFO_DEPTH = 1024;
  localparam logic [10:0] FIFO_CAP   = 11'h400;

  // ==========================================================
  // timing
  localparam int CLK_NS         = 50;
  localparam int TEMP_FAST_NS   = 10000000;
  localparam int TEMP_SLOW_NS   = 1280000000;
  localparam int TEMP_FAST_CYC  = TEMP_FAST_NS / CLK_NS;
  localparam int TEMP_SLOW_CYC  = TEMP_SLOW_NS / CLK_NS;

  // ==========================================================
  // link to core requests
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_END
  } linkOp_t;

  typedef struct packed {
    linkOp_t    op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } linkReq_t;

endpackage : imu_regs_pkg

// *** imu_temp_fifo_accel_conf_regs.sv ***
// Behaviour
// - temperature measurement stops while every sensor is suspended.
// - temperature word valid only while gyroscope status reads normal.
// - two's complement word, 0x0000 is 23 C, 0x8000 marks invalid.
// - gyroscope normal: temperature refreshed every 10 ms.
// - gyroscope suspended or fast start: temperature refreshed every 1.28 s.
// - byte counter shows committed fill level, zero when empty.
// - counter returns to zero after full readout or fifo flush command.
// - counter changes only when a whole frame is written or read, or on a fifo flush command.
// - burst reads drain the fifo; address stays at the readout port.
// - partly read frame is resent whole at the next readout.
// - fifo readout leaves the data ready indication untouched.
// - readout bytes follow the frame layout of the current fifo setup.
// - accel config read-write, reset 0x28, us, bandwidth, rate fields.
// - rate codes 1 to 12 legal; 0 and 13 to 15 reserved.
// - output data rate independent of accelerometer power mode.
// - bandwidth picks filter without undersampling, averaging with it.
// - clearing undersampling in low power moves accelerometer to normal.
// - low power command ignored while undersampling is cleared.
// - undefined bandwidth combination posts an error code.
// - temperature at 0x20 and 0x21, read-only, reset reads invalid 0x8000.
// - status flags read 1 while active, 0 while inactive.
`timescale 1ns/1ps
`default_nettype none

module imu_temp_fifo_accel_conf_regs
  import imu_regs_pkg::*;
#(
  parameter int TEMP_FAST_CYCLES = TEMP_FAST_CYC,
  parameter int TEMP_SLOW_CYCLES = TEMP_SLOW_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       linkClk,
  input  wire logic       linkStart,
  input  wire logic [7:0] linkStartAddr,
  input  wire logic       linkRead,
  input  wire logic       linkWrite,
  input  wire logic [7:0] linkWdata,
  input  wire logic       linkStop,
  output logic      [7:0] linkRdata,
  output logic            linkDone,
  output logic            linkBusy,
  input  wire logic [1:0] accPmuStatus,
  input  wire logic [1:0] gyroPmuStatus,
  input  wire logic [1:0] magPmuStatus,
  input  wire logic [15:0] tempSample,
  input  wire logic       accLowPowerCmd,
  input  wire logic       fifoFlushCmd,
  input  wire logic       fifoWrValid,
  input  wire logic [7:0] fifoWrData,
  input  wire logic       fifoWrLast,
  output logic            fifoWrReady,
  output logic            tempValid,
  output logic            tempRunning,
  output logic [3:0]      accOdr,
  output logic            accUndersample,
  output logic [2:0]      accFilterSel,
  output logic [2:0]      accAvgDepth,
  output logic            accToNormal,
  output logic            accLowPowerGo,
  output logic            accConfErr
);

  // ==========================================================
  // reset synchronisers, one per domain
  logic rstSync1_r, rstSync2_r, linkRst1_r, linkRst2_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      linkRst1_r <= 1'b0;
      linkRst2_r <= 1'b0;
    end else begin
      linkRst1_r <= 1'b1;
      linkRst2_r <= linkRst1_r;
    end
  end

  wire logic coreRstn = rstSync2_r;
  wire logic linkRstn = linkRst2_r;

  // ==========================================================
  // link side: address counter and request toggle
  linkReq_t   linkReq_r;
  logic       reqTog_r, linkBusy_r, linkDone_r;
  logic [7:0] linkAddr_r, linkRdata_r;
  logic       ackSync1_r, ackSync2_r, ackSeen_r;
  logic       ackTog_r;
  logic [7:0] coreRdata_r;

  wire logic linkAccess = (linkRead | linkWrite) & ~linkBusy_r;
  wire logic linkEnd    = linkStop & ~linkBusy_r & ~linkAccess;
  wire logic ackEdge    = ackSync2_r ^ ackSeen_r;
  wire logic addrHold   = (linkAddr_r == ADDR_FIFO_PORT);
  wire linkOp_t linkOp  = linkWrite ? OP_WRITE : OP_READ;

  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      linkAddr_r  <= 8'h00;
      linkReq_r   <= '{op: OP_READ, addr: 8'h00, wdata: 8'h00};
      reqTog_r    <= 1'b0;
      linkBusy_r  <= 1'b0;
      linkDone_r  <= 1'b0;
      linkRdata_r <= 8'h00;
      ackSync1_r  <= 1'b0;
      ackSync2_r  <= 1'b0;
      ackSeen_r   <= 1'b0;
    end else begin
      ackSync1_r <= ackTog_r;
      ackSync2_r <= ackSync1_r;
      ackSeen_r  <= ackSync2_r;
      linkDone_r <= 1'b0;
      if (linkStart && !linkBusy_r) begin
        linkAddr_r <= linkStartAddr;
      end else if (linkAccess) begin
        linkReq_r  <= '{op: linkOp, addr: linkAddr_r, wdata: linkWdata};
        reqTog_r   <= ~reqTog_r;
        linkBusy_r <= 1'b1;
        if (!addrHold) begin
          linkAddr_r <= linkAddr_r + 8'h01;
        end
      end else if (linkEnd) begin
        linkReq_r  <= '{op: OP_END, addr: linkAddr_r, wdata: 8'h00};
        reqTog_r   <= ~reqTog_r;
        linkBusy_r <= 1'b1;
      end
      if (ackEdge) begin
        linkBusy_r  <= 1'b0;
        linkDone_r  <= 1'b1;
        linkRdata_r <= coreRdata_r;
      end
    end
  end

  assign linkRdata = linkRdata_r;
  assign linkDone  = linkDone_r;
  assign linkBusy  = linkBusy_r;

  // ==========================================================
  // core side: request synchroniser
  logic reqSync1_r, reqSync2_r, reqSeen_r;

  always_ff @(posedge clk or negedge coreRstn) begin
    if (!coreRstn) begin
      reqSync1_r <= 1'b0;
      reqSync2_r <= 1'b0;
      reqSeen_r  <= 1'b0;
    end else begin
      reqSync1_r <= reqTog_r;
      reqSync2_r <= reqSync1_r;
      reqSeen_r  <= reqSync2_r;
    end
  end

  // request fields are stable while the toggle is in flight
  wire logic     reqFire = reqSync2_r ^ reqSeen_r;
  wire linkReq_t req     = linkReq_r;
  wire logic     isRead  = reqFire & (req.op == OP_READ);
  wire logic     isWrite = reqFire & (req.op == OP_WRITE);
  wire logic     isEnd   = reqFire & (req.op == OP_END);

  // ==========================================================
  // temperature word
  logic [15:0] tempWord_r;
  logic [31:0] tempCnt_r;

  wire logic allSuspend = (accPmuStatus == PMU_SUSPEND) & (gyroPmuStatus == PMU_SUSPEND)
                        & (magPmuStatus == PMU_SUSPEND);
  wire logic gyroNormal = (gyroPmuStatus == PMU_NORMAL);
  wire logic [31:0] tempPeriod = gyroNormal ? 32'(TEMP_FAST_CYCLES) : 32'(TEMP_SLOW_CYCLES);
  wire logic tempTick = (tempCnt_r >= tempPeriod - 32'h1);

  always_ff @(posedge clk or negedge coreRstn) begin
    if (!coreRstn) begin
      tempCnt_r   <= 32'h0;
      tempWord_r  <= TEMP_INVALID;
      tempValid   <= 1'b0;
      tempRunning <= 1'b0;
    end else begin
      tempValid   <= gyroNormal & ~allSuspend;
      tempRunning <= ~allSuspend;
      if (allSuspend) begin
        tempCnt_r <= 32'h0;
      end else if (tempTick) begin
        tempCnt_r  <= 32'h0;
        tempWord_r <= tempSample;
      end else begin
        tempCnt_r <= tempCnt_r + 32'h1;
      end
    end
  end

  // ==========================================================
  // frame fifo
  logic [8:0]  fifoMem [FIFO_DEPTH];
  logic [10:0] wrPtr_r, wrCommit_r, rdPtr_r, rdCommit_r;

  wire logic        fifoHasData = (rdPtr_r != wrCommit_r);
  wire logic        fifoPortRd  = isRead & (req.addr == ADDR_FIFO_PORT);
  wire logic        popByte     = fifoPortRd & fifoHasData;
  wire logic [8:0]  headEntry   = fifoMem[rdPtr_r[FIFO_AW-1:0]];
  wire logic        pushByte    = fifoWrValid & fifoWrReady;
  wire logic [10:0] fillLevel   = wrCommit_r - rdCommit_r;

  logic [10:0] wrPtr_nxt, wrCommit_nxt, rdPtr_nxt, rdCommit_nxt;

  always_comb begin
    wrPtr_nxt    = wrPtr_r;
    wrCommit_nxt = wrCommit_r;
    rdPtr_nxt    = rdPtr_r;
    rdCommit_nxt = rdCommit_r;
    if (pushByte) begin
      wrPtr_nxt = wrPtr_r + 11'h1;
      // level moves on frame end only
      if (fifoWrLast) begin
        wrCommit_nxt = wrPtr_r + 11'h1;
      end
    end
    if (popByte) begin
      rdPtr_nxt = rdPtr_r + 11'h1;
      if (headEntry[8]) begin
        rdCommit_nxt = rdPtr_r + 11'h1;
      end
    end else if (isEnd) begin
      rdPtr_nxt = rdCommit_r;
    end
    if (fifoFlushCmd) begin
      wrPtr_nxt    = 11'h0;
      wrCommit_nxt = 11'h0;
      rdPtr_nxt    = 11'h0;
      rdCommit_nxt = 11'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (pushByte) begin
      fifoMem[wrPtr_r[FIFO_AW-1:0]] <= {fifoWrLast, fifoWrData};
    end
  end

  always_ff @(posedge clk or negedge coreRstn) begin
    if (!coreRstn) begin
      wrPtr_r     <= 11'h0;
      wrCommit_r  <= 11'h0;
      rdPtr_r     <= 11'h0;
      rdCommit_r  <= 11'h0;
      fifoWrReady <= 1'b0;
    end else begin
      wrPtr_r     <= wrPtr_nxt;
      wrCommit_r  <= wrCommit_nxt;
      rdPtr_r     <= rdPtr_nxt;
      rdCommit_r  <= rdCommit_nxt;
      fifoWrReady <= ((wrPtr_nxt - rdCommit_nxt) < FIFO_CAP);
    end
  end

  // ==========================================================
  // accelerometer configuration
  logic [7:0] accConf_r;

  // only the config location is writable
  wire logic       confWrite = isWrite & (req.addr == ADDR_ACCEL_CONF);
  wire logic [7:0] wd        = req.wdata;
  wire logic [3:0] wOdr      = wd[ODR_MSB:ODR_LSB];
  wire logic [2:0] wBwp      = wd[BWP_MSB:BWP_LSB];
  wire logic odrBad = (wOdr < ODR_MIN) | (wOdr > ODR_MAX);
  wire logic bwpBad = ~wd[US_BIT] & (wBwp > BWP_FILTER_MAX);
  wire logic usDrop = confWrite & ~wd[US_BIT] & (accPmuStatus == PMU_LOW_POWER);
  wire logic usNow  = accConf_r[US_BIT];

  always_ff @(posedge clk or negedge coreRstn) begin
    if (!coreRstn) begin
      accConf_r     <= ACCEL_CONF_RST;
      accToNormal   <= 1'b0;
      accLowPowerGo <= 1'b0;
      accConfErr    <= 1'b0;
    end else begin
      if (confWrite) begin
        accConf_r <= wd;
      end
      accToNormal   <= usDrop;
      accLowPowerGo <= accLowPowerCmd & usNow & ~usDrop;
      // flag high while illegal setting stands
      if (confWrite) begin
        accConfErr <= odrBad | bwpBad;
      end
    end
  end

  // rate taken straight from the register
  assign accOdr         = accConf_r[ODR_MSB:ODR_LSB];
  assign accUndersample = accConf_r[US_BIT];

  always_ff @(posedge clk or negedge coreRstn) begin
    if (!coreRstn) begin
      accFilterSel <= ACCEL_CONF_RST[BWP_MSB:BWP_LSB];
      accAvgDepth  <= 3'h0;
    end else begin
      accFilterSel <= usNow ? 3'h0 : accConf_r[BWP_MSB:BWP_LSB];
      accAvgDepth  <= usNow ? accConf_r[BWP_MSB:BWP_LSB] : 3'h0;
    end
  end

  // ==========================================================
  // read mux and answer toggle
  logic [7:0] readMux;

  always_comb begin
    readMux = UNMAPPED_BYTE;
    unique case (req.addr)
      ADDR_TEMP_LSB:   readMux = tempWord_r[7:0];
      ADDR_TEMP_MSB:   readMux = tempWord_r[15:8];
      ADDR_FILL_LSB:   readMux = fillLevel[7:0];
      ADDR_FILL_MSB:   readMux = {5'h00, fillLevel[10:8]};
      ADDR_FIFO_PORT:  readMux = fifoHasData ? headEntry[7:0] : FIFO_EMPTY_BYTE;
      ADDR_ACCEL_CONF: readMux = accConf_r;
      default:         readMux = UNMAPPED_BYTE;
    endcase
  end

  // readout touches no data ready state
  always_ff @(posedge clk or negedge coreRstn) begin
    if (!coreRstn) begin
      coreRdata_r <= 8'h00;
      ackTog_r    <= 1'b0;
    end else if (reqFire) begin
      coreRdata_r <= isRead ? readMux : 8'h00;
      ackTog_r    <= ~ackTog_r;
    end
  end

endmodule : imu_temp_fifo_accel_conf_regs

`default_nettype wire

// *** imu_temp_fifo_accel_conf_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module imu_temp_fifo_accel_conf_regs_test;
  import imu_regs_pkg::*;
  localparam int FAST = 20;
  localparam int SLOW = 50;
  logic clk = 1'h0, linkClk = 1'h0, rstn = 1'h0;
  logic linkStart, linkRead, linkWrite, linkStop, linkDone, linkBusy;
  logic [7:0] linkStartAddr, linkWdata, linkRdata, rd;
  logic [1:0] accPmuStatus = 2'h0, gyroPmuStatus = 2'h0, magPmuStatus = 2'h0;
  logic [15:0] tempSample = 16'h1234;
  logic accLowPowerCmd = 1'h0, fifoFlushCmd = 1'h0, fifoWrValid = 1'h0, fifoWrLast = 1'h0;
  logic [7:0] fifoWrData = 8'h00;
  logic fifoWrReady, tempValid, tempRunning, accUndersample, accToNormal, accLowPowerGo;
  logic accConfErr;
  logic [3:0] accOdr;
  logic [2:0] accFilterSel, accAvgDepth;
  wire logic [11:0] outs = {accConfErr, accUndersample, accFilterSel, accAvgDepth, accOdr};
  int errors = 0, num_checks = 0, seed = 32'hBD52, cyc = 0, goCnt = 0, normCnt = 0;
  logic [7:0] fq[$];
  imu_temp_fifo_accel_conf_regs #(.TEMP_FAST_CYCLES(FAST), .TEMP_SLOW_CYCLES(SLOW))
  imu_temp_fifo_accel_conf_regs_inst (
    .clk, .rstn, .linkClk, .linkStart, .linkStartAddr, .linkRead, .linkWrite,
    .linkWdata, .linkStop, .linkRdata, .linkDone, .linkBusy, .accPmuStatus,
    .gyroPmuStatus, .magPmuStatus, .tempSample, .accLowPowerCmd, .fifoFlushCmd,
    .fifoWrValid, .fifoWrData, .fifoWrLast, .fifoWrReady, .tempValid, .tempRunning,
    .accOdr, .accUndersample, .accFilterSel, .accAvgDepth, .accToNormal,
    .accLowPowerGo, .accConfErr);
  imu_link_host imu_link_host_inst (.linkClk, .linkDone, .linkRdata, .linkStart,
    .linkStartAddr, .linkRead, .linkWrite, .linkWdata, .linkStop);
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #62.5 linkClk = ~linkClk;
  end
  always @(posedge clk) begin
    cyc++;
    if (accLowPowerGo === 1'h1) goCnt++;
    if (accToNormal === 1'h1) normCnt++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================================
  // helpers
  task automatic summarize;
    errors += imu_link_host_inst.late;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [11:0] expOut(input logic [7:0] c);
    logic bad;
    bad = c[3:0] == 4'h0 || c[3:0] > 4'hC || (!c[7] && c[6:4] > 3'h2);
    return {bad, c[7], c[7] ? 3'h0 : c[6:4], c[7] ? c[6:4] : 3'h0, c[3:0]};
  endfunction : expOut
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic lk(input int k, input logic [7:0] v);
    imu_link_host_inst.req(k, v, rd);
  endtask : lk
  task automatic rdw(input logic [7:0] a, output logic [15:0] w);
    logic [7:0] lo;
    lk(2, a);
    lk(0, 8'h00);
    lo = rd;
    lk(0, 8'h00);
    w = {rd, lo};
    lk(3, 8'h00);
  endtask : rdw
  task automatic wrc(input logic [7:0] a, input logic [7:0] v);
    lk(2, a);
    lk(1, v);
    lk(3, 8'h00);
  endtask : wrc
  task automatic pulse(input logic lp);
    tick(1);
    accLowPowerCmd = lp;
    fifoFlushCmd = !lp;
    tick(1);
    accLowPowerCmd = 1'h0;
    fifoFlushCmd = 1'h0;
  endtask : pulse
  task automatic push(input logic l);
    int i;
    int r;
    r = $random(seed);
    tick(1);
    fifoWrValid = 1'h1;
    fifoWrData = r[7:0];
    fifoWrLast = l;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (fifoWrReady === 1'h1) break;
    end
    #2;
    fifoWrValid = 1'h0;
    fifoWrData = ~r[7:0];
    fq.push_back(r[7:0]);
  endtask : push
  // ==========================================================
  // main sequence
  initial begin : main
    logic [15:0] w, t;
    logic [7:0] c;
    int i, r;
    repeat (5) @(posedge clk);
    #2 rstn = 1'h1;
    repeat (4) @(posedge linkClk);
    rdw(ADDR_TEMP_LSB, w);
    chk(w, TEMP_INVALID);
    rdw(ADDR_ACCEL_CONF, w);
    chk(w, {8'h00, ACCEL_CONF_RST});
    chk(outs, expOut(ACCEL_CONF_RST));
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      c = {r[7:4], i[3:0]};
      wrc(ADDR_ACCEL_CONF, c);
      rdw(ADDR_ACCEL_CONF, w);
      chk(w, {8'h00, c});
      chk(outs, expOut(c));
    end
    tick(1);
    accPmuStatus = PMU_LOW_POWER;
    wrc(ADDR_ACCEL_CONF, 8'h88);
    pulse(1'h1);
    wrc(ADDR_ACCEL_CONF, 8'h08);
    pulse(1'h1);
    tick(4);
    chk(16'(goCnt), 16'h0001);
    chk(16'(normCnt), 16'h0001);
    chk(outs, expOut(8'h08));
    r = $random(seed);
    gyroPmuStatus = PMU_NORMAL;
    tempSample = r[15:0];
    tick(FAST + 10);
    rdw(ADDR_TEMP_LSB, w);
    chk(w, tempSample);
    chk(tempValid, 1'h1);
    wrc(ADDR_TEMP_LSB, ~w[7:0]);
    rdw(ADDR_TEMP_LSB, t);
    chk(t, tempSample);
    tick(1);
    {accPmuStatus, gyroPmuStatus} = 4'h0;
    tempSample = ~w;
    tick(SLOW + 20);
    chk(tempRunning, 1'h0);
    rdw(ADDR_TEMP_LSB, t);
    chk(t, ~tempSample);
    tick(1);
    accPmuStatus = PMU_NORMAL;
    tick(SLOW + 20);
    rdw(ADDR_TEMP_LSB, w);
    chk(w, tempSample);
    chk({tempValid, tempRunning}, 16'h0001);
    imu_link_host_inst.gap = 3;
    for (i = 0; i < 7; i++) push(i == 3);
    wrc(ADDR_FILL_LSB, 8'h55);
    rdw(ADDR_FILL_LSB, w);
    chk(w, 16'h0004);
    push(1'h1);
    lk(2, ADDR_FIFO_PORT);
    for (i = 0; i < 2; i++) begin
      lk(0, 8'h00);
      chk(rd, fq[i]);
    end
    lk(3, 8'h00);
    rdw(ADDR_FILL_LSB, w);
    chk(w, 16'h0008);
    lk(2, ADDR_FIFO_PORT);
    for (i = 0; i < 9; i++) begin
      lk(0, 8'h00);
      chk(rd, i < 8 ? fq[i] : FIFO_EMPTY_BYTE);
    end
    lk(3, 8'h00);
    rdw(ADDR_FILL_LSB, w);
    chk(w, 16'h0000);
    for (i = 0; i < 4; i++) push(i == 3);
    pulse(1'h0);
    rdw(ADDR_FILL_LSB, w);
    chk(w, 16'h0000);
    summarize();
  end
endmodule : imu_temp_fifo_accel_conf_regs_test
`default_nettype wire
